// ---- machine_check_dsi_logic.sv ----
`timescale 1ns/1ps
module machine_check_dsi_logic
  import mchk_dsi_pkg::*;
#(
  parameter int DC_WAYS     = 8,
  parameter int IC_WAYS     = 8,
  parameter int DRT_ENTRIES = 4
)(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // AXI4-Lite register slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins from the system, active low
  input  wire logic              mchk_pin_n,
  input  wire logic              transfer_error_ack_n,
  input  wire logic              memtest_request_pin_n,
  // Internal consistency checks
  input  wire logic [DC_WAYS-1:0]     dc_data_tag_hit,
  input  wire logic [DC_WAYS-1:0]     dc_snoop_tag_hit,
  input  wire logic                   dc_reload_valid,
  input  wire logic [DC_WAYS-1:0]     dc_victim_sel,
  input  wire logic [IC_WAYS-1:0]     ic_tag_hit,
  input  wire logic [1:0]             l2_tag_hit,
  input  wire logic [1:0]             dtlb_hit,
  input  wire logic [DRT_ENTRIES-1:0] drt_hit,
  input  wire logic                   l2_data_parity_err,
  input  wire logic                   sysbus_data_parity_err,
  input  wire logic                   sysbus_addr_parity_err,
  // Memory test engine
  input  wire logic              memtest_done,
  input  wire logic              memtest_fail_dc,
  input  wire logic              memtest_fail_ic,
  input  wire logic              memtest_fail_l2,
  input  wire logic              memtest_fail_br,
  input  wire logic              memtest_fail_tlb,
  output logic                   memtest_run,
  // Instruction flow
  input  wire logic [31:0]       instr_ea,
  output logic                   mchk_take,
  output logic                   redirect_valid,
  output logic [31:0]            redirect_addr,
  output logic                   checkstop,
  // Data access checks
  input  wire logic              acc_valid,
  input  wire logic [31:0]       acc_ea,
  input  wire logic              acc_store,
  input  wire logic              acc_quad,
  input  wire logic              acc_reserve,
  input  wire logic              acc_write_through,
  input  wire logic              acc_page_fault,
  input  wire logic              acc_align_fault,
  input  wire logic              direct_store_flag,
  output logic                   dsi_take,
  output logic                   align_take
);

  // Widths the hit checks can serve
  if (DC_WAYS < 2 || DC_WAYS > 32 || IC_WAYS < 2 || IC_WAYS > 32 ||
      DRT_ENTRIES < 2 || DRT_ENTRIES > 32)
  begin : g_bad_width
    $error("machine_check_dsi_logic: way or entry count out of 2..32");
  end

  // More than one bit set
  function automatic logic multi_hit(input logic [31:0] v);
    return (v & (v - 32'h0000_0001)) != 32'h0000_0000;
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  logic [31:0] control;
  logic [31:0] mstate;
  logic [31:0] save_restore_addr;
  logic [31:0] machine_check_save_state;
  logic [31:0] breakpoint_register;
  logic [31:0] fault_data_addr;
  logic [3:0]  dsi_cause;
  run_mode_t   mode;
  logic        strap_pending;
  logic        memtest_armed;
  logic [2:0]  pin_raw;
  logic [2:0]  pin_lvl;
  logic [2:0]  pin_prev;
  logic [2:0]  pin_s2;
  logic [2:0]  pin_s3;

  // Pins inverted to active high
  assign pin_raw = {~memtest_request_pin_n, ~transfer_error_ack_n, ~mchk_pin_n};

  // Three-stage pin synchronisers; a level counts once stages two and three agree
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    logic [2:0] chain;
    always_ff @(posedge core_clk)
    begin
      chain <= {chain[1:0], pin_raw[i]};
    end
    assign pin_s2[i] = chain[1];
    assign pin_s3[i] = chain[2];
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
      if (sys_rst)
        pin_lvl[i] <= 1'b0;
      else if (pin_s2[i] == pin_s3[i])
        pin_lvl[i] <= pin_s3[i];
    end
  end

  // Edge memory so a held pin raises one event
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pin_prev <= 3'h0;
    else
      pin_prev <= pin_lvl;
  end

  wire frozen = (mode == MODE_CHECKSTOP);
  wire int_en = control[CTL_INT_CHK_EN];
  wire mt     = memtest_run & ~frozen;

  // Strap caught on the first edge after reset release, then test runs to done
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_pending <= 1'b1;
      memtest_run   <= 1'b0;
      memtest_armed <= 1'b0;
    end
    else if (strap_pending)
    begin
      strap_pending <= 1'b0;
      memtest_run   <= pin_s3[2] & (pin_s2[2] == pin_s3[2]);
      memtest_armed <= pin_s3[2] & (pin_s2[2] == pin_s3[2]);
    end
    else if (memtest_done & ~frozen)
      memtest_run <= 1'b0;
  end

  // Cause collection
  logic [NCAUSE-1:0] cause;
  always_comb
  begin
    cause = '0;
    cause[C_DC]  = multi_hit(32'(dc_data_tag_hit)) | multi_hit(32'(dc_snoop_tag_hit))
                 | (dc_reload_valid & (dc_victim_sel == '0 | multi_hit(32'(dc_victim_sel))))
                 | (mt & memtest_fail_dc);
    cause[C_IC]  = multi_hit(32'(ic_tag_hit)) | (mt & memtest_fail_ic);
    cause[C_L2TAG] = (&l2_tag_hit) | (mt & memtest_fail_l2);
    cause[C_BR]  = mt & memtest_fail_br;
    cause[C_TLB] = (&dtlb_hit) | (mt & memtest_fail_tlb);
    cause[C_OTH] = ((|dc_data_tag_hit) & (|drt_hit)) | multi_hit(32'(drt_hit));
    cause[C_OTH:C_IC] = cause[C_OTH:C_IC] & {6{int_en}};
    cause[C_L2_DATA_PARITY_FLAG] = l2_data_parity_err;
    cause[C_MCP] = pin_lvl[0] & ~pin_prev[0] & control[CTL_MCHK_PIN_EN];
    cause[C_TEA] = pin_lvl[1] & ~pin_prev[1];
    cause[C_DP]  = sysbus_data_parity_err & control[CTL_DATA_PAR_EN];
    cause[C_AP]  = sysbus_addr_parity_err & control[CTL_ADDR_PAR_EN];
  end

  wire any_cause = (|cause) & ~frozen;
  wire take_mc   = any_cause & mstate[MS_ME];

  // Save state image: flags for present causes, all else zero but the vector bit
  logic [31:0] next_save_state;
  always_comb
  begin
    next_save_state = 32'h0000_0000;
    for (int c = 0; c < NCAUSE; c++)
    begin
      next_save_state[SAVE_POS[c]] = cause[c];
    end
    next_save_state[SAVE_VEC] = mstate[MS_VEC];
  end

  // Checkstop: entered on the edge after the cause, left only by reset
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mode <= MODE_RUN;
    else if (any_cause & ~mstate[MS_ME])
      mode <= MODE_CHECKSTOP;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      checkstop <= 1'b0;
    else if (any_cause & ~mstate[MS_ME])
      checkstop <= 1'b1;
  end

  // Bus write path
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] waddr;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire wr_do  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ok  = wr_do & ~frozen;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == REG_CONTROL || a == REG_MSTATE || a == REG_SAVE_ADDR || a == REG_SAVE_ST
        || a == REG_BREAKPT || a == REG_FAULT_DA || a == REG_STATUS;
  endfunction

  // Address and data taken in either order; response after both
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      waddr         <= '0;
      wdata         <= WORD_RESET;
      wstrb         <= 4'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~aw_hs & ~s_axi_bvalid & ~wr_do;
      s_axi_wready  <= ~w_held & ~w_hs & ~s_axi_bvalid & ~wr_do;
      if (aw_hs)
      begin
        aw_held <= 1'b1;
        waddr   <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_held <= 1'b1;
        wdata  <= s_axi_wdata;
        wstrb  <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  wire wr_ctl  = wr_ok & (waddr == REG_CONTROL);
  wire wr_ms   = wr_ok & (waddr == REG_MSTATE);
  wire wr_sa   = wr_ok & (waddr == REG_SAVE_ADDR);
  wire wr_ss   = wr_ok & (waddr == REG_SAVE_ST);
  wire wr_bp   = wr_ok & (waddr == REG_BREAKPT);
  wire wr_fda  = wr_ok & (waddr == REG_FAULT_DA);

  // Software controls; frozen in checkstop like the other software-written registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      control             <= CONTROL_RESET;
      breakpoint_register <= WORD_RESET;
    end
    else
    begin
      if (wr_ctl)
        control <= merge(control, wdata, wstrb);
      if (wr_bp)
        breakpoint_register <= merge(breakpoint_register, wdata, wstrb);
    end
  end

  // Machine state; the exception update wins over a software write
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mstate <= MSTATE_RESET;
    else if (take_mc)
    begin
      mstate        <= mstate & ~MS_CLEAR_ON_MCHK;
      mstate[MS_LE] <= mstate[MS_ILE];
    end
    else if (wr_ms)
      mstate <= merge(mstate, wdata, wstrb);
  end

  // Save registers loaded on exception entry
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      save_restore_addr        <= WORD_RESET;
      machine_check_save_state <= WORD_RESET;
    end
    else if (take_mc)
    begin
      save_restore_addr        <= instr_ea;
      machine_check_save_state <= next_save_state;
    end
    else
    begin
      if (wr_sa)
        save_restore_addr <= merge(save_restore_addr, wdata, wstrb);
      if (wr_ss)
        machine_check_save_state <= merge(machine_check_save_state, wdata, wstrb);
    end
  end

  // Handler redirect, one cycle after the cause
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mchk_take      <= 1'b0;
      redirect_valid <= 1'b0;
      redirect_addr  <= WORD_RESET;
    end
    else
    begin
      mchk_take      <= take_mc;
      redirect_valid <= take_mc;
      if (take_mc)
        redirect_addr <= (mstate[MS_IP] ? VEC_BASE_HIGH : WORD_RESET) | VEC_MCHK_OFFSET;
    end
  end

  // Data access checks; quad-word accesses drop the lowest compared address bit
  logic [31:0] bp_mask;
  logic        bp_hit;
  logic        ds_hit;
  logic        rsv_hit;
  logic        pf_hit;
  always_comb
  begin
    bp_mask = 32'hFFFF_FFF8;
    if (acc_quad)
      bp_mask[BP_QUAD_BIT] = 1'b0;
    bp_hit  = ((acc_ea & bp_mask) == (breakpoint_register & bp_mask))
            & (acc_store ? breakpoint_register[BP_WR_EN] : breakpoint_register[BP_RD_EN]);
    ds_hit  = direct_store_flag;
    rsv_hit = acc_reserve & acc_write_through;
    pf_hit  = acc_page_fault;
  end

  wire dsi_now = acc_valid & ~frozen & (bp_hit | ds_hit | rsv_hit | pf_hit);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dsi_take        <= 1'b0;
      align_take      <= 1'b0;
      dsi_cause       <= 4'h0;
      fault_data_addr <= WORD_RESET;
    end
    else
    begin
      dsi_take   <= dsi_now;
      align_take <= acc_valid & ~frozen & acc_align_fault & ~dsi_now;
      if (dsi_now)
      begin
        dsi_cause       <= {bp_hit, ds_hit, rsv_hit, pf_hit};
        fault_data_addr <= acc_quad ? {acc_ea[31:4], 4'h0} : acc_ea;
      end
      else if (wr_fda)
        fault_data_addr <= merge(fault_data_addr, wdata, wstrb);
    end
  end

  // Status word shows live block state
  logic [31:0] status;
  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_CHECKSTOP] = frozen;
    status[ST_MT_RUN]    = memtest_run;
    status[ST_MT_ARMED]  = memtest_armed;
    status[ST_DSI_PF]    = dsi_cause[0];
    status[ST_DSI_RSV]   = dsi_cause[1];
    status[ST_DSI_DS]    = dsi_cause[2];
    status[ST_DSI_BP]    = dsi_cause[3];
  end

  logic [31:0] rd_word;
  always_comb
  begin
    case (s_axi_araddr)
      REG_CONTROL:   rd_word = control;
      REG_MSTATE:    rd_word = mstate;
      REG_SAVE_ADDR: rd_word = save_restore_addr;
      REG_SAVE_ST:   rd_word = machine_check_save_state;
      REG_BREAKPT:   rd_word = breakpoint_register;
      REG_FAULT_DA:  rd_word = fault_data_addr;
      REG_STATUS:    rd_word = status;
      default:       rd_word = WORD_RESET;
    endcase
  end

  // Read channel; reads still answer in checkstop so software can inspect
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= WORD_RESET;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else
      s_axi_arready <= ~s_axi_rvalid;
  end

endmodule

// ---- mcd_sva.sv ----
`timescale 1ns/1ps
module mcd_sva
  import mchk_dsi_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Exception outputs
  input wire logic        mchk_take,
  input wire logic        redirect_valid,
  input wire logic [31:0] redirect_addr,
  input wire logic        checkstop,
  // Data access side
  input wire logic        acc_valid,
  input wire logic        acc_page_fault,
  input wire logic        acc_reserve,
  input wire logic        acc_write_through,
  input wire logic        direct_store_flag,
  input wire logic        dsi_take,
  input wire logic        align_take
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Handler entry only at the two legal vectors, never while stopped
  AST_REDIRECT: assert property (
    redirect_valid |-> mchk_take && !checkstop && (redirect_addr == VEC_MCHK_OFFSET ||
    redirect_addr == (VEC_BASE_HIGH | VEC_MCHK_OFFSET))) else $error("bad handler redirect");
  // Enable is cleared by the take, so a follow-up cause cannot be taken
  AST_ONE_TAKE: assert property (
    $rose(mchk_take) |=> !mchk_take [*2]) else $error("machine check taken twice");
  // Only reset leaves checkstop
  AST_CS_STAYS: assert property (
    checkstop |=> checkstop) else $error("checkstop dropped");
  // Frozen state: no events, vector held
  AST_CS_FROZEN: assert property (
    checkstop |=> $stable(redirect_addr) && !mchk_take && !dsi_take && !align_take)
    else $error("activity in checkstop");
  AST_PAGE_FAULT: assert property (
    acc_valid && acc_page_fault && !checkstop |=> dsi_take && !align_take) else $error("page fault missed");
  AST_RSV_WT: assert property (
    acc_valid && acc_reserve && acc_write_through && !checkstop |=> dsi_take) else $error("reservation missed");
  AST_DIRECT_STORE: assert property (
    acc_valid && direct_store_flag && !checkstop |=> dsi_take && !align_take) else $error("direct store missed");
  AST_ALIGN_CAUSE: assert property (
    $rose(align_take) |-> $past(acc_valid) && !dsi_take) else $error("stray alignment event");
  AST_NO_SPURIOUS: assert property (
    !acc_valid |=> !dsi_take && !align_take) else $error("storage event without access");
endmodule

bind machine_check_dsi_logic mcd_sva u_sva (.core_clk, .sys_rst, .mchk_take, .redirect_valid, .redirect_addr,
  .checkstop, .acc_valid, .acc_page_fault, .acc_reserve, .acc_write_through, .direct_store_flag, .dsi_take,
  .align_take);

// ---- mchk_dsi_pkg.sv ----
package mchk_dsi_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CONTROL   = 8'h00;
  localparam logic [7:0] REG_MSTATE    = 8'h04;
  localparam logic [7:0] REG_SAVE_ADDR = 8'h08;
  localparam logic [7:0] REG_SAVE_ST   = 8'h0C;
  localparam logic [7:0] REG_BREAKPT   = 8'h10;
  localparam logic [7:0] REG_FAULT_DA  = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;

  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] MSTATE_RESET  = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // Control register fields
  localparam int CTL_MCHK_PIN_EN = 0;
  localparam int CTL_ADDR_PAR_EN = 1;
  localparam int CTL_DATA_PAR_EN = 2;
  localparam int CTL_INT_CHK_EN  = 3;

  // Machine state fields, bit 0 is the least significant
  localparam int MS_VEC  = 25;
  localparam int MS_ILE  = 16;
  localparam int MS_ME   = 12;
  localparam int MS_IP   = 6;
  localparam int MS_RI   = 1;
  localparam int MS_LE   = 0;

  // Power, interrupt, privilege, float, enable, float modes, trace, translation, monitor, recoverable
  localparam logic [31:0] MS_CLEAR_ON_MCHK = 32'h0004_FFB6;

  // Cause indices and their save-state positions
  localparam int NCAUSE  = 11;
  localparam int C_IC    = 0;
  localparam int C_DC    = 1;
  localparam int C_L2TAG = 2;
  localparam int C_TLB   = 3;
  localparam int C_BR    = 4;
  localparam int C_OTH   = 5;
  localparam int C_L2_DATA_PARITY_FLAG  = 6;
  localparam int C_MCP   = 7;
  localparam int C_TEA   = 8;
  localparam int C_DP    = 9;
  localparam int C_AP    = 10;
  localparam int SAVE_POS [NCAUSE] = '{30, 29, 28, 27, 26, 16, 21, 20, 19, 18, 17};
  localparam int SAVE_VEC = 25;

  // Breakpoint register fields
  localparam int BP_RD_EN = 0;
  localparam int BP_WR_EN = 1;
  localparam int BP_QUAD_BIT = 3;

  // Status register fields
  localparam int ST_CHECKSTOP = 0;
  localparam int ST_MT_RUN    = 1;
  localparam int ST_MT_ARMED  = 2;
  localparam int ST_DSI_PF    = 8;
  localparam int ST_DSI_RSV   = 9;
  localparam int ST_DSI_DS    = 10;
  localparam int ST_DSI_BP    = 11;

  // Exception vectors
  localparam logic [31:0] VEC_MCHK_OFFSET = 32'h0000_0200;
  localparam logic [31:0] VEC_BASE_HIGH   = 32'hFFF0_0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {MODE_RUN, MODE_CHECKSTOP} run_mode_t;

endpackage

// ---- sysbus_agent.sv ----
`timescale 1ns/1ps
module sysbus_agent (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Bench commands: transfer error, pin, data parity, address parity
  input  wire logic [3:0] fire,
  // Error signalling toward the core
  output logic            transfer_error_ack_n,
  output logic            mchk_pin_n,
  output logic            sysbus_data_parity_err,
  output logic            sysbus_addr_parity_err,
  output logic            memtest_request_pin_n
);
  logic [1:0] pin_hold;
  logic [1:0] tea_hold;

  // Strap held for the whole reset so the synchroniser fills
  assign memtest_request_pin_n = !sys_rst;
  assign mchk_pin_n            = (pin_hold == 2'h0);
  assign transfer_error_ack_n  = (tea_hold == 2'h0);

  // Parity errors last one cycle; pin and transfer error held two so the core's filter sees them
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {sysbus_data_parity_err, sysbus_addr_parity_err} <= 2'b00;
      pin_hold <= 2'h0;
      tea_hold <= 2'h0;
    end
    else
    begin
      {sysbus_data_parity_err, sysbus_addr_parity_err} <= {fire[2], fire[3]};
      pin_hold <= fire[1] ? 2'h2 : pin_hold - 2'(pin_hold != 2'h0);
      tea_hold <= fire[0] ? 2'h2 : tea_hold - 2'(tea_hold != 2'h0);
    end
  end
endmodule

// ---- tb_machine_check_dsi_logic.sv ----
`timescale 1ns/1ps
module tb_machine_check_dsi_logic;
  import mchk_dsi_pkg::*;
  typedef struct packed {logic [4:0] f; logic [1:0] sq; logic [31:0] ea; logic [1:0] ex;} row_t;
  logic        core_clk, sys_rst, awv, awr, wv, wrd, bv, bre, arv, arr, rv, rre, got;
  logic [7:0]  awa, ara, dct, dcs, dcv, ict;
  logic [31:0] wd, rdat, iea, aea, raddr;
  logic [1:0]  bresp, rresp, l2h, tlbh;
  logic [3:0]  drt, fire;
  logic        dcrv, l2_data_parity_flag, mtd, mtbr, mtr, take, rdv, cs, av, ast, aq, ars, awt, apf, aal, dsf, dsi, alt;
  logic        pin_n, tea_n, strap_n, dpe, ape;
  int          mismatches = 0;
  int          n_compared = 0;
  // Fields: page fault, reserve, write-through, direct store, align; store, quad
  row_t rows [10] = '{{5'b10000, 2'b10, 32'h0000_0000, 2'b10}, {5'b01100, 2'b10, 32'h0000_0000, 2'b10},
    {5'b01000, 2'b10, 32'h0000_0000, 2'b00}, {5'b00100, 2'b10, 32'h0000_0000, 2'b00},
    {5'b00011, 2'b10, 32'h0000_0000, 2'b10}, {5'b00001, 2'b10, 32'h0000_0000, 2'b01},
    {5'b00000, 2'b10, 32'h0000_1004, 2'b00}, {5'b00000, 2'b10, 32'h0000_100C, 2'b10},
    {5'b00000, 2'b00, 32'h0000_100C, 2'b00}, {5'b00000, 2'b11, 32'h0000_1004, 2'b10}};

  machine_check_dsi_logic uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .mchk_pin_n(pin_n),
    .transfer_error_ack_n(tea_n), .memtest_request_pin_n(strap_n), .dc_data_tag_hit(dct),
    .dc_snoop_tag_hit(dcs), .dc_reload_valid(dcrv), .dc_victim_sel(dcv), .ic_tag_hit(ict), .l2_tag_hit(l2h),
    .dtlb_hit(tlbh), .drt_hit(drt), .l2_data_parity_err(l2_data_parity_flag), .sysbus_data_parity_err(dpe),
    .sysbus_addr_parity_err(ape), .memtest_done(mtd), .memtest_fail_dc(1'b0), .memtest_fail_ic(1'b0),
    .memtest_fail_l2(1'b0), .memtest_fail_br(mtbr), .memtest_fail_tlb(1'b0), .memtest_run(mtr),
    .instr_ea(iea), .mchk_take(take), .redirect_valid(rdv), .redirect_addr(raddr), .checkstop(cs),
    .acc_valid(av), .acc_ea(aea), .acc_store(ast), .acc_quad(aq), .acc_reserve(ars),
    .acc_write_through(awt), .acc_page_fault(apf), .acc_align_fault(aal), .direct_store_flag(dsf),
    .dsi_take(dsi), .align_take(alt));

  sysbus_agent partner (.core_clk(core_clk), .sys_rst(sys_rst), .fire(fire), .transfer_error_ack_n(tea_n),
    .mchk_pin_n(pin_n), .sysbus_data_parity_err(dpe), .sysbus_addr_parity_err(ape),
    .memtest_request_pin_n(strap_n));

  // 250 MHz core clock
  initial
  begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: saw %h, wanted %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
    do
    begin
      @(posedge core_clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end
    while (bv !== 1'b1);
    bre <= 0;
    chk(32'(bresp), 32'(RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge core_clk);
    {ara, arv, rre} <= {a, 2'b11};
    do
    begin
      @(posedge core_clk);
      if (arr) arv <= 0;
    end
    while (rv !== 1'b1);
    rre <= 0;
    chk(rdat, e);
    chk(32'(rresp), 32'(r));
  endtask

  task automatic acc(input row_t r);
    @(posedge core_clk);
    {apf, ars, awt, dsf, aal, ast, aq, aea, av} <= {r.f, r.sq, r.ea, 1'b1};
    @(posedge core_clk);
    av <= 0;
    #1 chk(32'({dsi, alt}), 32'(r.ex));
  endtask

  // One cycle of one cause; index follows the save-state cause order
  task automatic cause(input int k);
    @(posedge core_clk);
    case (k)
      0: ict <= 8'h03;
      1: dct <= 8'h81;
      2: l2h <= 2'b11;
      3: tlbh <= 2'b11;
      4: mtbr <= 1;
      5: drt <= 4'h3;
      6: l2_data_parity_flag <= 1;
      7: fire <= 4'h2;
      8: fire <= 4'h1;
      9: fire <= 4'h4;
      10: fire <= 4'h8;
      11: dcs <= 8'h0C;
      12: dcrv <= 1;
      default: {dcrv, dcv} <= {1'b1, 8'h18};
    endcase
    @(posedge core_clk);
    {ict, dct, dcs, dcv, l2h, tlbh, drt, fire, mtbr, l2_data_parity_flag, dcrv} <= '0;
  endtask

  // Pins pass a synchroniser, so look over a span of cycles
  task automatic wait_take(output logic t);
    t = 0;
    repeat (12)
    begin
      #1 if (take === 1'b1) t = 1;
      @(posedge core_clk);
    end
  endtask

  // Hang guard, far beyond the expected run
  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    {awv, wv, bre, arv, rre, dcrv, l2_data_parity_flag, mtd, mtbr, av, ast, aq, ars, awt, apf, aal, dsf} = '0;
    {awa, ara, wd, aea, l2h, tlbh, dct, dcs, dcv, ict, drt, fire} = '0;
    iea = 32'h0000_4A5C;
    sys_rst = 1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
    repeat (2) @(posedge core_clk);
    #1 chk(32'(mtr), 32'h1);
    rd_chk(REG_CONTROL, CONTROL_RESET, RESP_OKAY);
    rd_chk(REG_MSTATE, MSTATE_RESET, RESP_OKAY);
    rd_chk(REG_STATUS, 32'h0000_0006, RESP_OKAY);
    rd_chk(8'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(REG_BREAKPT, 32'h0000_100A);
    foreach (rows[i]) acc(rows[i]);
    rd_chk(REG_FAULT_DA, 32'h0000_1000, RESP_OKAY);
    rd_chk(REG_STATUS, 32'h0000_0806, RESP_OKAY);
    // Every cause with all checks on; enable, byte order and base set
    wr(REG_CONTROL, 32'h0000_000F);
    for (int k = 0; k < 14; k++)
    begin
      wr(REG_MSTATE, 32'h0201_1040);
      cause(k);
      wait_take(got);
      chk(32'(got), 32'h1);
      chk(raddr, 32'hFFF0_0200);
      rd_chk(REG_SAVE_ST, (32'h1 << SAVE_POS[k > 10 ? C_DC : k]) | 32'h0200_0000, RESP_OKAY);
      rd_chk(REG_MSTATE, 32'h0201_0041, RESP_OKAY);
      rd_chk(REG_SAVE_ADDR, iea, RESP_OKAY);
    end
    // Checks off: gated causes ignored, transfer error still taken
    wr(REG_CONTROL, 32'h0000_0000);
    wr(REG_MSTATE, 32'h0000_1000);
    for (int k = 0; k < 11; k++)
    begin
      if (k != 6 && k != 8)
      begin
        cause(k);
        wait_take(got);
        chk(32'(got), 32'h0);
      end
    end
    cause(8);
    wait_take(got);
    chk(32'(got), 32'h1);
    @(posedge core_clk);
    mtd <= 1;
    @(posedge core_clk);
    mtd <= 0;
    #1 chk(32'(mtr), 32'h0);
    // Enable now clear: a cause stops the core
    cause(6);
    #1 chk(32'(cs), 32'h1);
    cause(3);
    wait_take(got);
    chk(32'({got, cs}), 32'h1);
    wr(REG_CONTROL, 32'h0000_000F);
    rd_chk(REG_CONTROL, 32'h0000_0000, RESP_OKAY);
    acc(rows[0] & ~41'h3);
    @(posedge core_clk);
    sys_rst <= 1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 0;
    repeat (2) @(posedge core_clk);
    #1 chk(32'(cs), 32'h0);
    tally_and_finish();
  end
endmodule
